// >>> core/rsc_pkg.sv
// Constants, types and shared decode for the reset strap capture block
package rsc_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Management register map
   localparam logic [4:0] REG_PAGE_SELECT = 5'h1f;
   localparam logic [4:0] REG_CFG_OVERRIDE = 5'h10;
   localparam logic [4:0] REG_CFG_STATUS = 5'h11;
   localparam logic [15:0] CFG_PAGE = 16'h0000;
   localparam logic [15:0] PAGE_SELECT_RST = 16'h0000;
   localparam logic [15:0] RDATA_NONE = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////////
   // Override register fields
   localparam int unsigned OVR_TX_CLOCK_PIN = 0;
   localparam int unsigned OVR_AN = 1;
   localparam int unsigned OVR_DDR = 2;
   localparam int unsigned OVR_SPD_LO = 3;
   localparam int unsigned OVR_GPIO1 = 5;
   localparam int unsigned OVR_ROLE = 6;
   localparam int unsigned OVR_SERIAL = 7;

   ////////////////////////////////////////////////////////////////////////////////
   // Status register fields
   localparam int unsigned STS_ADDR_LO = 0;
   localparam int unsigned STS_REF_LO = 5;
   localparam int unsigned STS_HW15 = 7;
   localparam int unsigned STS_FTEST = 8;
   localparam int unsigned STS_RSVD = 9;
   localparam int unsigned STS_MII = 10;
   localparam int unsigned STS_VALID = 11;

   ////////////////////////////////////////////////////////////////////////////////
   // Encodings and reset values
   localparam logic [1:0] SPD_10 = 2'h0;
   localparam logic [1:0] SPD_100 = 2'h1;
   localparam logic [1:0] SPD_1000 = 2'h2;
   localparam logic [1:0] SPD_RSVD = 2'h3;
   localparam logic [1:0] REF_10M = 2'h0;
   localparam logic [1:0] REF_12M8 = 2'h1;
   localparam logic [1:0] REF_25M = 2'h2;
   localparam logic [1:0] REF_125M = 2'h3;
   localparam logic [4:0] FACTORY_TEST_ADDR = 5'h1f;
   localparam int unsigned GPIO1_DRIVE_BIT = 2;
   localparam logic [2:0] GPIO_ONE_FUNCTION_SELECT_RST = 3'h0;
   localparam logic [4:0] PHY_ADDR_RST = 5'h00;
   localparam logic [1:0] TWO_BIT_RST = 2'h0;

   typedef enum logic [1:0]
   {
      RSC_ST_CAPTURE = 2'b01,
      RSC_ST_HOLD = 2'b10
   } rsc_cap_state_t;

   // Parallel interface runs plain MII at 10 or 100 without double data rate
   function automatic logic rsc_is_mii(input logic ddr, input logic [1:0] spd);
   begin
      return !ddr && (spd == SPD_10 || spd == SPD_100);
   end
   endfunction : rsc_is_mii

endpackage : rsc_pkg

// >>> core/rsc_strap_sampler.sv
// One-shot sampler of the strap pins at reset release
`timescale 1ns/100ps
module rsc_strap_sampler
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // Strap pins
   input wire logic tx_clock_pin_i,
   input wire logic rx_valid_pin_i,
   input wire logic carrier_sense_pin_i,
   input wire logic [7:0] rxd_pin_i,
   input wire logic general_out_one_pin_i,
   input wire logic general_out_two_pin_i,
   input wire logic rx_error_pin_i,
   input wire logic collision_pin_i,
   // Captured values
   output logic cap_tx_o,
   output logic cap_an_o,
   output logic cap_ddr_o,
   output logic [1:0] cap_spd_o,
   output logic cap_general_out_one_pin_o,
   output logic cap_general_out_two_pin_o,
   output logic [4:0] cap_addr_o,
   output logic [1:0] cap_ref_o,
   output logic cap_hw15_o,
   output logic cap_pulse_o
);

   rsc_pkg::rsc_cap_state_t state_ff;
   rsc_pkg::rsc_cap_state_t nxt_state;
   logic take;

   assign take = (state_ff == rsc_pkg::RSC_ST_CAPTURE);

   always_comb
   begin
      case (state_ff)
         rsc_pkg::RSC_ST_CAPTURE: nxt_state = rsc_pkg::RSC_ST_HOLD;
         rsc_pkg::RSC_ST_HOLD: nxt_state = rsc_pkg::RSC_ST_HOLD;
         default: nxt_state = rsc_pkg::RSC_ST_CAPTURE;
      endcase
   end

   // R13: single capture
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state_ff <= rsc_pkg::RSC_ST_CAPTURE;
         cap_pulse_o <= 1'b0;
         cap_tx_o <= 1'b0;
         cap_an_o <= 1'b0;
         cap_ddr_o <= 1'b0;
         cap_spd_o <= rsc_pkg::TWO_BIT_RST;
         cap_general_out_one_pin_o <= 1'b0;
         cap_general_out_two_pin_o <= 1'b0;
         cap_addr_o <= rsc_pkg::PHY_ADDR_RST;
         cap_ref_o <= rsc_pkg::TWO_BIT_RST;
         cap_hw15_o <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         cap_pulse_o <= take;
         if (take)
         begin
            cap_tx_o <= tx_clock_pin_i;
            cap_an_o <= rx_valid_pin_i;
            cap_ddr_o <= carrier_sense_pin_i;
            cap_spd_o <= rxd_pin_i[1:0];
            cap_general_out_one_pin_o <= general_out_one_pin_i;
            cap_general_out_two_pin_o <= general_out_two_pin_i;
            cap_addr_o <= {rx_error_pin_i, rxd_pin_i[7:4]};
            cap_ref_o <= rxd_pin_i[3:2];
            cap_hw15_o <= collision_pin_i;
         end
      end
   end

endmodule : rsc_strap_sampler

// >>> core/rsc_mode_decode.sv
// Decode of the parallel interface mode from speed and double data rate
`timescale 1ns/100ps
module rsc_mode_decode
(
   // Mode selection
   input wire logic ddr_i,
   input wire logic [1:0] speed_i,
   // Decoded mode
   output logic mii_o,
   output logic gmii_o,
   output logic rgmii_o,
   output logic reserved_o
);

   logic spd_rsvd;

   // R4: speed decode
   assign spd_rsvd = (speed_i == rsc_pkg::SPD_RSVD);
   assign mii_o = rsc_pkg::rsc_is_mii(ddr_i, speed_i);
   assign gmii_o = !ddr_i && (speed_i == rsc_pkg::SPD_1000);
   assign rgmii_o = ddr_i && !spd_rsvd;
   assign reserved_o = spd_rsvd;

endmodule : rsc_mode_decode

// >>> core/rsc_strap_config.sv
// Reset strap capture and management override of interface configuration
// Function
// R1: Transmit-clock strap loads clock output enable; drives 125MHz clock; ignored in MII.
// R2: Receive-valid strap loads auto-negotiation enable, one enables.
// R3: Carrier-sense strap loads double data rate; low receive data loads speed.
// R4: Speed 00 is 10, 01 is 100, 10 is 1000, 11 reserved.
// R5: First general-output strap loads GPIO1 select bit 2, clock output.
// R6: Second general-output strap: role bit in MII, else serial flavour; MII forces SGMII.
// R7: PHY address from receive-error pin (bit 4) and receive data 7..4.
// R8: Captured address all ones enters factory test; boards must avoid it.
// R9: Receive data 3..2 select reference clock frequency 10, 12.8, 25, 125MHz.
// R10: Collision strap selects 3-pin or 15-pin hardware configuration mode.
// R11: Reference clock may only change while the device is powered down.
// R12: Page-select at address 31 maps later register addresses onto that page.
// R13: Straps sampled once at reset release; held until reset or management override.
`timescale 1ns/100ps
module rsc_strap_config
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // Strap pins
   input wire logic tx_clock_pin_i,
   input wire logic rx_valid_pin_i,
   input wire logic carrier_sense_pin_i,
   input wire logic [7:0] rxd_pin_i,
   input wire logic general_out_one_pin_i,
   input wire logic general_out_two_pin_i,
   input wire logic rx_error_pin_i,
   input wire logic collision_pin_i,
   // Management register access
   input wire logic mgmt_wr_i,
   input wire logic mgmt_rd_i,
   input wire logic [4:0] mgmt_addr_i,
   input wire logic [15:0] mgmt_wdata_i,
   output logic [15:0] mgmt_rdata_o,
   output logic mgmt_rvalid_o,
   output logic [15:0] mgmt_page_o,
   // Configuration outputs
   output logic config_valid_o,
   output logic tx_clock_out_enable_o,
   output logic tx_clock_drive_o,
   output logic autoneg_enable_o,
   output logic ddr_select_o,
   output logic [1:0] speed_field_o,
   output logic mii_mode_o,
   output logic speed_reserved_o,
   output logic [2:0] gpio_one_function_select_o,
   output logic terminal_role_bit_o,
   output logic serial_flavour_bit_o,
   output logic [4:0] phy_addr_o,
   output logic factory_test_o,
   output logic [1:0] ref_clk_freq_o,
   output logic hw_mode_15pin_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Strap sampling
   logic cap_tx, cap_an, cap_ddr, cap_general_out_one_pin, cap_general_out_two_pin, cap_hw15, cap_pulse;
   logic [1:0] cap_spd, cap_ref;
   logic [4:0] cap_addr;

   rsc_strap_sampler u_sampler
   (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .tx_clock_pin_i(tx_clock_pin_i),
      .rx_valid_pin_i(rx_valid_pin_i),
      .carrier_sense_pin_i(carrier_sense_pin_i),
      .rxd_pin_i(rxd_pin_i),
      .general_out_one_pin_i(general_out_one_pin_i),
      .general_out_two_pin_i(general_out_two_pin_i),
      .rx_error_pin_i(rx_error_pin_i),
      .collision_pin_i(collision_pin_i),
      .cap_tx_o(cap_tx),
      .cap_an_o(cap_an),
      .cap_ddr_o(cap_ddr),
      .cap_spd_o(cap_spd),
      .cap_general_out_one_pin_o(cap_general_out_one_pin),
      .cap_general_out_two_pin_o(cap_general_out_two_pin),
      .cap_addr_o(cap_addr),
      .cap_ref_o(cap_ref),
      .cap_hw15_o(cap_hw15),
      .cap_pulse_o(cap_pulse)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Management decode
   logic tx_en_ff, an_ff, ddr_ff, gpio_drv_ff, role_ff, serial_ff, valid_ff;
   logic [1:0] spd_ff;
   logic [15:0] page_ff;
   logic on_cfg_page, page_wr, ovr_wr, rd_page, rd_ovr, rd_sts;
   logic [15:0] ovr_word, sts_word, nxt_rdata;

   assign on_cfg_page = (page_ff == rsc_pkg::CFG_PAGE);
   // R12: page select decode
   assign page_wr = mgmt_wr_i && (mgmt_addr_i == rsc_pkg::REG_PAGE_SELECT);
   assign ovr_wr = mgmt_wr_i && valid_ff && on_cfg_page
                   && (mgmt_addr_i == rsc_pkg::REG_CFG_OVERRIDE);
   assign rd_page = mgmt_addr_i == rsc_pkg::REG_PAGE_SELECT;
   assign rd_ovr = on_cfg_page && (mgmt_addr_i == rsc_pkg::REG_CFG_OVERRIDE);
   assign rd_sts = on_cfg_page && (mgmt_addr_i == rsc_pkg::REG_CFG_STATUS);

   ////////////////////////////////////////////////////////////////////////////////
   // Next configuration
   logic nxt_tx_en, nxt_an, nxt_ddr, nxt_gpio_drv, nxt_role, nxt_serial;
   logic [1:0] nxt_spd;
   logic dec_mii, dec_rsvd, nxt_tx_drive;

   // R1: transmit clock enable
   assign nxt_tx_en = cap_pulse ? cap_tx : ovr_wr ? mgmt_wdata_i[rsc_pkg::OVR_TX_CLOCK_PIN] : tx_en_ff;
   // R2: auto-negotiation enable
   assign nxt_an = cap_pulse ? cap_an : ovr_wr ? mgmt_wdata_i[rsc_pkg::OVR_AN] : an_ff;
   // R3: interface mode bits
   assign nxt_ddr = cap_pulse ? cap_ddr : ovr_wr ? mgmt_wdata_i[rsc_pkg::OVR_DDR] : ddr_ff;
   assign nxt_spd = cap_pulse ? cap_spd
                  : ovr_wr ? mgmt_wdata_i[rsc_pkg::OVR_SPD_LO +: 2] : spd_ff;
   // R5: GPIO1 clock select
   assign nxt_gpio_drv = cap_pulse ? cap_general_out_one_pin
                       : ovr_wr ? mgmt_wdata_i[rsc_pkg::OVR_GPIO1] : gpio_drv_ff;

   rsc_mode_decode u_decode
   (
      .ddr_i(nxt_ddr),
      .speed_i(nxt_spd),
      .mii_o(dec_mii),
      .gmii_o(),
      .rgmii_o(),
      .reserved_o(dec_rsvd)
   );

   // R6: role or serial flavour
   assign nxt_role = cap_pulse ? (dec_mii && cap_general_out_two_pin)
                   : ovr_wr ? (dec_mii && mgmt_wdata_i[rsc_pkg::OVR_ROLE]) : role_ff;
   assign nxt_serial = cap_pulse ? (!dec_mii && cap_general_out_two_pin)
                     : ovr_wr ? (!dec_mii && mgmt_wdata_i[rsc_pkg::OVR_SERIAL]) : serial_ff;
   // R1: clock ignored in MII
   assign nxt_tx_drive = nxt_tx_en && !dec_mii;

   ////////////////////////////////////////////////////////////////////////////////
   // Read data
   logic [4:0] addr_ff;
   logic [1:0] ref_ff;
   logic hw15_ff, ftest_ff, mii_ff, rsvd_ff;

   assign ovr_word = {8'h00, serial_ff, role_ff, gpio_drv_ff, spd_ff, ddr_ff, an_ff, tx_en_ff};
   assign sts_word = {4'h0, valid_ff, mii_ff, rsvd_ff, ftest_ff, hw15_ff, ref_ff, addr_ff};
   assign nxt_rdata = rd_page ? page_ff : rd_ovr ? ovr_word : rd_sts ? sts_word
                    : rsc_pkg::RDATA_NONE;

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         tx_en_ff <= 1'b0;
         an_ff <= 1'b0;
         ddr_ff <= 1'b0;
         spd_ff <= rsc_pkg::TWO_BIT_RST;
         gpio_drv_ff <= 1'b0;
         role_ff <= 1'b0;
         serial_ff <= 1'b0;
         mii_ff <= 1'b0;
         rsvd_ff <= 1'b0;
         tx_clock_drive_o <= 1'b0;
      end
      else
      begin
         tx_en_ff <= nxt_tx_en;
         an_ff <= nxt_an;
         ddr_ff <= nxt_ddr;
         spd_ff <= nxt_spd;
         gpio_drv_ff <= nxt_gpio_drv;
         role_ff <= nxt_role;
         serial_ff <= nxt_serial;
         mii_ff <= dec_mii;
         rsvd_ff <= dec_rsvd;
         tx_clock_drive_o <= nxt_tx_drive;
      end
   end

   // R7: PHY address, R9: reference clock, R10: hardware mode
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         addr_ff <= rsc_pkg::PHY_ADDR_RST;
         ref_ff <= rsc_pkg::TWO_BIT_RST;
         hw15_ff <= 1'b0;
         ftest_ff <= 1'b0;
         valid_ff <= 1'b0;
      end
      else if (cap_pulse)
      begin
         addr_ff <= cap_addr;
         ref_ff <= cap_ref;
         hw15_ff <= cap_hw15;
         // R8: factory test address
         ftest_ff <= (cap_addr == rsc_pkg::FACTORY_TEST_ADDR);
         valid_ff <= 1'b1;
      end
   end

   // R12: page select register
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         page_ff <= rsc_pkg::PAGE_SELECT_RST;
         mgmt_rdata_o <= rsc_pkg::RDATA_NONE;
         mgmt_rvalid_o <= 1'b0;
      end
      else
      begin
         if (page_wr)
            page_ff <= mgmt_wdata_i;
         mgmt_rvalid_o <= mgmt_rd_i;
         if (mgmt_rd_i)
            mgmt_rdata_o <= nxt_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign mgmt_page_o = page_ff;
   assign config_valid_o = valid_ff;
   assign tx_clock_out_enable_o = tx_en_ff;
   assign autoneg_enable_o = an_ff;
   assign ddr_select_o = ddr_ff;
   assign speed_field_o = spd_ff;
   assign mii_mode_o = mii_ff;
   assign speed_reserved_o = rsvd_ff;
   assign gpio_one_function_select_o = {gpio_drv_ff, 2'b00};
   assign terminal_role_bit_o = role_ff;
   assign serial_flavour_bit_o = serial_ff;
   assign phy_addr_o = addr_ff;
   assign factory_test_o = ftest_ff;
   assign ref_clk_freq_o = ref_ff;
   assign hw_mode_15pin_o = hw15_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);

   a_tx_clock_pin_capture: assert property ($rose(config_valid_o) |-> // R1
      tx_clock_out_enable_o == $past(tx_clock_pin_i, 2))
      else $error("tx clock enable not taken from strap");
   a_tx_clock_pin_mii_gate: assert property (config_valid_o |-> // R1
      tx_clock_drive_o == (tx_clock_out_enable_o && !mii_mode_o))
      else $error("tx clock drive wrong for mode");
   a_autoneg_capture: assert property ($rose(config_valid_o) |-> // R2
      autoneg_enable_o == $past(rx_valid_pin_i, 2))
      else $error("autoneg enable not taken from strap");
   a_mode_capture: assert property ($rose(config_valid_o) |-> // R3
      ddr_select_o == $past(carrier_sense_pin_i, 2)
      && speed_field_o == $past(rxd_pin_i[1:0], 2))
      else $error("interface mode not taken from straps");
   a_speed_decode: assert property (config_valid_o |-> // R4
      mii_mode_o == rsc_pkg::rsc_is_mii(ddr_select_o, speed_field_o)
      && speed_reserved_o == (speed_field_o == rsc_pkg::SPD_RSVD))
      else $error("speed decode wrong");
   a_gpio1_capture: assert property ($rose(config_valid_o) |-> // R5
      gpio_one_function_select_o[rsc_pkg::GPIO1_DRIVE_BIT] == $past(general_out_one_pin_i, 2))
      else $error("GPIO1 select not taken from strap");
   a_role_capture: assert property ($rose(config_valid_o) |-> // R6
      (mii_mode_o ? (terminal_role_bit_o == $past(general_out_two_pin_i, 2))
                  : (serial_flavour_bit_o == $past(general_out_two_pin_i, 2))))
      else $error("second strap loaded wrong bit");
   a_mii_forces_sgmii: assert property (mii_mode_o |-> !serial_flavour_bit_o) // R6
      else $error("serial flavour set in MII mode");
   a_phy_addr_capture: assert property ($rose(config_valid_o) |-> // R7
      phy_addr_o == {$past(rx_error_pin_i, 2), $past(rxd_pin_i[7:4], 2)})
      else $error("PHY address not taken from straps");
   a_factory_test: assert property (config_valid_o |-> // R8
      factory_test_o == (phy_addr_o == rsc_pkg::FACTORY_TEST_ADDR))
      else $error("factory test flag wrong");
   a_reference_clock_capture: assert property ($rose(config_valid_o) |-> // R9
      ref_clk_freq_o == $past(rxd_pin_i[3:2], 2))
      else $error("reference clock setting not taken from straps");
   a_hw_mode_capture: assert property ($rose(config_valid_o) |-> // R10
      hw_mode_15pin_o == $past(collision_pin_i, 2))
      else $error("hardware mode not taken from strap");
   a_page_select: assert property (mgmt_wr_i && mgmt_addr_i == rsc_pkg::REG_PAGE_SELECT // R12
      |=> mgmt_page_o == $past(mgmt_wdata_i)
      ##1 ($past(page_wr) || mgmt_page_o == $past(mgmt_page_o)))
      else $error("page select not stored");
   a_capture_once: assert property (config_valid_o && !ovr_wr |=> config_valid_o // R13
      && $stable(phy_addr_o) && $stable(autoneg_enable_o) && $stable(speed_field_o))
      else $error("configuration changed without override");

   c_mii_capture: cover property ($rose(config_valid_o) && mii_mode_o);
   c_rgmii_capture: cover property ($rose(config_valid_o) && ddr_select_o);
   c_override: cover property (ovr_wr ##1 mgmt_rd_i);
   c_page_then_read: cover property (page_wr ##[1:4] (mgmt_rd_i && !rd_page));

endmodule : rsc_strap_config

// >>> tb/rsc_strap_board.sv
// Board strap model driving the multiplexed pins around reset
`timescale 1ns/100ps
module rsc_strap_board
(
   // Clock and control
   input wire logic core_clk_i,
   input wire logic [14:0] strap_word_i,
   input wire logic churn_i,
   // Strap pins
   output logic tx_clock_pin_o,
   output logic rx_valid_pin_o,
   output logic carrier_sense_pin_o,
   output logic [7:0] rxd_pin_o,
   output logic general_out_one_pin_o,
   output logic general_out_two_pin_o,
   output logic rx_error_pin_o,
   output logic collision_pin_o
);
   logic [14:0] churn_ff;
   logic [14:0] level;

   ////////////////////////////////////////////////////////////////////////////////
   // After capture the pins carry live traffic, modelled as a moving pattern
   always_ff @(posedge core_clk_i)
   begin
      churn_ff <= churn_i ? churn_ff + 15'h1235 : 15'h0000;
   end

   // straps held steady while churn_i is low
   // Straps stay steady through reset; the test picks the address, all ones only on purpose
   assign level = churn_i ? (~strap_word_i ^ churn_ff) : strap_word_i;
   assign rxd_pin_o = level[7:0];
   assign tx_clock_pin_o = level[8];
   assign rx_valid_pin_o = level[9];
   assign carrier_sense_pin_o = level[10];
   assign general_out_one_pin_o = level[11];
   assign general_out_two_pin_o = level[12];
   assign rx_error_pin_o = level[13];
   assign collision_pin_o = level[14];
endmodule : rsc_strap_board

// >>> tb/test_reset_strap_config_capture.sv
// Self-checking bench for the reset strap capture block
`timescale 1ns/100ps
module test_reset_strap_config_capture;
   logic core_clk_i, rstn_i, churn, tx_p, rxdv_p, crs_p, general_out_one_pin_p, general_out_two_pin_p, rxer_p, col_p;
   logic [7:0] rxd_p;
   logic [14:0] strap_word;
   logic mgmt_wr_i, mgmt_rd_i, mgmt_rvalid_o, config_valid_o, tx_en_o, tx_drv_o, an_o, ddr_o;
   logic mii_o, rsvd_o, role_o, serial_o, ftest_o, hw15_o;
   logic [4:0] mgmt_addr_i, addr_o;
   logic [15:0] mgmt_wdata_i, mgmt_rdata_o, page_o;
   logic [1:0] spd_o, ref_o;
   logic [2:0] gpio_o;
   int error_cnt = 0;
   int check_count = 0;
   localparam logic [14:0] STRAPS [6] = '{15'h5b20, 15'h2055, 15'h519a, 15'h27ff, 15'h1530,
      15'h4441};

   rsc_strap_board i_board (.core_clk_i(core_clk_i), .strap_word_i(strap_word),
      .churn_i(churn), .tx_clock_pin_o(tx_p), .rx_valid_pin_o(rxdv_p),
      .carrier_sense_pin_o(crs_p), .rxd_pin_o(rxd_p), .general_out_one_pin_o(general_out_one_pin_p),
      .general_out_two_pin_o(general_out_two_pin_p), .rx_error_pin_o(rxer_p), .collision_pin_o(col_p));

   rsc_strap_config i_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .tx_clock_pin_i(tx_p),
      .rx_valid_pin_i(rxdv_p), .carrier_sense_pin_i(crs_p), .rxd_pin_i(rxd_p),
      .general_out_one_pin_i(general_out_one_pin_p), .general_out_two_pin_i(general_out_two_pin_p),
      .rx_error_pin_i(rxer_p), .collision_pin_i(col_p), .mgmt_wr_i(mgmt_wr_i),
      .mgmt_rd_i(mgmt_rd_i), .mgmt_addr_i(mgmt_addr_i), .mgmt_wdata_i(mgmt_wdata_i),
      .mgmt_rdata_o(mgmt_rdata_o), .mgmt_rvalid_o(mgmt_rvalid_o), .mgmt_page_o(page_o),
      .config_valid_o(config_valid_o), .tx_clock_out_enable_o(tx_en_o),
      .tx_clock_drive_o(tx_drv_o), .autoneg_enable_o(an_o), .ddr_select_o(ddr_o),
      .speed_field_o(spd_o), .mii_mode_o(mii_o), .speed_reserved_o(rsvd_o),
      .gpio_one_function_select_o(gpio_o), .terminal_role_bit_o(role_o),
      .serial_flavour_bit_o(serial_o), .phy_addr_o(addr_o), .factory_test_o(ftest_o),
      .ref_clk_freq_o(ref_o), .hw_mode_15pin_o(hw15_o));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and watchdog
   initial
   begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   initial
   begin
      repeat (5000) @(posedge core_clk_i);
      error_cnt++;
      $display("BAD watchdog expected completion seen hang");
      stop_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test

   task automatic mgmt_write(input logic [4:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      mgmt_wr_i <= 1'b1;
      mgmt_addr_i <= a;
      mgmt_wdata_i <= d;
      @(posedge core_clk_i);
      mgmt_wr_i <= 1'b0;
      @(posedge core_clk_i);
      #1;
   endtask : mgmt_write

   task automatic mgmt_read(input logic [4:0] a, input logic [15:0] exp, input string nm);
      @(posedge core_clk_i);
      mgmt_rd_i <= 1'b1;
      mgmt_addr_i <= a;
      @(posedge core_clk_i);
      mgmt_rd_i <= 1'b0;
      #1;
      check({nm, " valid"}, 16'(mgmt_rvalid_o), 16'h0001);
      check(nm, mgmt_rdata_o, exp);
      @(posedge core_clk_i);
      #1;
      check({nm, " valid drop"}, 16'(mgmt_rvalid_o), 16'h0000);
   endtask : mgmt_read

   task automatic apply_reset(input logic [14:0] s);
      int n;
      n = 0;
      @(posedge core_clk_i);
      rstn_i <= 1'b0;
      churn <= 1'b0;
      strap_word <= s;
      repeat (16) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      while (config_valid_o !== 1'b1 && n < 10)
      begin
         @(posedge core_clk_i);
         n++;
      end
      #1;
      check("config valid", 16'(config_valid_o), 16'h0001);
      check("page reset", page_o, rsc_pkg::PAGE_SELECT_RST);
   endtask : apply_reset

   task automatic check_straps(input logic [14:0] s);
      logic mii;
      logic [4:0] adr;
      mii = !s[10] && !s[1];
      adr = {s[13], s[7:4]};
      check("tx enable", 16'(tx_en_o), 16'(s[8]));
      check("tx drive", 16'(tx_drv_o), 16'(s[8] && !mii));
      check("autoneg", 16'(an_o), 16'(s[9]));
      check("ddr", 16'(ddr_o), 16'(s[10]));
      check("speed", 16'(spd_o), 16'(s[1:0]));
      check("mii", 16'(mii_o), 16'(mii));
      check("reserved", 16'(rsvd_o), 16'(s[1:0] == 2'h3));
      check("gpio select", 16'(gpio_o), 16'({s[11], 2'h0}));
      check("role", 16'(role_o), 16'(mii && s[12]));
      check("serial", 16'(serial_o), 16'(!mii && s[12]));
      check("address", 16'(addr_o), 16'(adr));
      check("factory test", 16'(ftest_o), 16'(adr == 5'h1f));
      check("ref clock", 16'(ref_o), 16'(s[3:2]));
      check("hw mode", 16'(hw15_o), 16'(s[14]));
      mgmt_read(rsc_pkg::REG_CFG_STATUS, 16'({1'b1, mii, s[1:0] == 2'h3, adr == 5'h1f, s[14],
         s[3:2], adr}), "status");
   endtask : check_straps

   ////////////////////////////////////////////////////////////////////////////////
   // Test sequence
   initial
   begin
      rstn_i = 1'b0;
      churn = 1'b0;
      strap_word = 15'h0000;
      mgmt_wr_i = 1'b0;
      mgmt_rd_i = 1'b0;
      mgmt_addr_i = 5'h00;
      mgmt_wdata_i = 16'h0000;
      foreach (STRAPS[i])
      begin
         apply_reset(STRAPS[i]);
         check_straps(STRAPS[i]);
      end
      $display("test capture table done");
      churn <= 1'b1;
      repeat (8) @(posedge core_clk_i);
      check_straps(STRAPS[5]);
      $display("test pins ignored after capture done");
      mgmt_write(rsc_pkg::REG_PAGE_SELECT, 16'h0003);
      check("page select", page_o, 16'h0003);
      mgmt_read(rsc_pkg::REG_PAGE_SELECT, 16'h0003, "page read");
      mgmt_write(rsc_pkg::REG_CFG_OVERRIDE, 16'h00b5);
      check("other page write", 16'(spd_o), 16'h0001);
      mgmt_read(rsc_pkg::REG_CFG_OVERRIDE, 16'h0000, "other page read");
      mgmt_write(rsc_pkg::REG_PAGE_SELECT, rsc_pkg::CFG_PAGE);
      mgmt_write(rsc_pkg::REG_CFG_OVERRIDE, 16'h00b5);
      check("ovr speed", 16'(spd_o), 16'h0002);
      check("ovr drive", 16'(tx_drv_o), 16'h0001);
      check("ovr serial", 16'(serial_o), 16'h0001);
      check("ovr gpio", 16'(gpio_o), 16'h0004);
      check("ovr autoneg", 16'(an_o), 16'h0000);
      mgmt_read(rsc_pkg::REG_CFG_OVERRIDE, 16'h00b5, "ovr read");
      mgmt_write(rsc_pkg::REG_CFG_OVERRIDE, 16'h0041);
      check("mii tx enable", 16'(tx_en_o), 16'h0001);
      check("mii role", 16'(role_o), 16'h0001);
      check("mii serial", 16'(serial_o), 16'h0000);
      check("mii mode", 16'(mii_o), 16'h0001);
      check("mii drive", 16'(tx_drv_o), 16'h0000);
      mgmt_read(5'h05, rsc_pkg::RDATA_NONE, "unmapped read");
      check("address kept", 16'(addr_o), 16'h0004);
      $display("test management override done");
      stop_test();
   end
endmodule : test_reset_strap_config_capture
